//--- core/spied_core.sv
`timescale 1ns/100ps
// What this block does
// (R1) Bytes shift in and out most significant bit first, opcode byte first.
// (R2) Unknown opcode: ignore everything until chip select rises.
// (R3) Decode set/clear write enable and status read, bit 3 ignored.
// (R4) Decode status write, array read and write; bit 3 is address bit nine.
// (R5) 0x83/0x82 pick id page or lock by address bit 7.
// (R6) Master sends id offset in bits 3..0, or bit 7 alone for lock.
// (R7) Write enable latch must be set first, only by set-write-enable.
// (R8) After set/clear write enable opcode, act only at deselection.
// (R9) Latch clears at power-up, clear command, write end, write protect low.
// (R10) Status read always honoured, repeats current status while selected.
// (R11) Status byte: ones, protect high, protect low, latch, busy.
// (R12) During status write, latch and busy live; protect bits after end.
// (R13) Busy is 1 exactly while a write cycle runs.
// (R14) Latch clear rejects every array write and status write.
// (R15) Protect bits non-volatile, status-write only, guard regions.
// (R16) Status write executes only if deselected right after data byte.
// (R17) Byte-aligned deselect starts timed cycle; protect bits update at end.
// (R18) Cycle end clears latch and busy; protect bits change only after a status write.
// (R19) Reject status write if latch clear, busy, or protect pin low.
// (R20) Array read loads address and streams bytes, wrapping to zero.
// (R21) Array read ends on any chip select rise; any start address.
// (R22) Array read rejected while busy; high address bits by capacity.
// (R23) Sample input on clock rise, drive output on clock fall.
// (R24) Not selected after power-up until a chip select falling edge.
// (R25) Protect 00 none, 01 upper quarter, 10 upper half, 11 all.
// (R26) Deselection discards partial commands and returns to opcode phase.
// (R27) Without id page, 1000 001x opcodes are invalid.
module spied_core #(
  parameter int ADDR_W = 9,
  parameter bit HAS_ID_PAGE = 1'b1,
  parameter int unsigned WRITE_CYCLES = spied_pkg::TW_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic wp_n,
  output logic sdo,
  output logic sdo_oe
);

  localparam int TW_W = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DATA, ST_RD_STATUS,
    ST_RD_ARRAY, ST_RD_ID, ST_RD_LOCK, ST_WAIT
  } spied_state_t;

  typedef enum logic [2:0] {
    K_NONE, K_SET_WE, K_CLR_WE, K_STATUS_WR,
    K_ARRAY_RD, K_ARRAY_WR, K_ID_RD, K_ID_WR
  } spied_kind_t;

  logic [2:0] cs_sync;
  logic [2:0] sck_sync;
  logic [1:0] sdi_sync;
  logic [1:0] wp_sync;
  logic armed;
  logic selected;
  spied_state_t state;
  spied_kind_t kind;
  spied_kind_t wr_kind;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] out_byte;
  logic [7:0] data_byte;
  logic data_seen;
  logic a8;
  logic lock_sel;
  logic [ADDR_W-1:0] addr;
  logic [3:0] id_off;
  logic wp_low_seen;
  logic write_enable_latch;
  logic busy_flag;
  logic [TW_W-1:0] timer;
  logic [1:0] block_protect;
  logic [1:0] pend_bp;
  logic id_locked;
  logic [ADDR_W-1:0] wr_addr;
  logic [3:0] wr_id_off;
  logic [7:0] wr_data;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] id_mem [0:15];

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_in;
  logic [8:0] addr_full;
  logic [ADDR_W-1:0] addr_new;
  logic [7:0] status;
  logic wr_done;
  logic aligned;
  logic wr_ok;
  logic start_wr;

  // Protected region test for an array address
  function automatic logic is_protected(input logic [1:0] bp_v,
                                        input logic [ADDR_W-1:0] a);
    case (bp_v) // R25
      2'h0: return 1'b0;
      2'h1: return &a[ADDR_W-1 -: 2];
      2'h2: return a[ADDR_W-1];
      2'h3: return 1'b1;
    endcase
  endfunction

  // Pins are asynchronous to sys_clk; first stage feeds only the second.
  // Chip select resets low, so only a real high level on the pin arms
  // selection; a pin held low through reset never fakes a falling edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync <= 3'h0; // R24
      sck_sync <= 3'h0;
      sdi_sync <= 2'h0;
      wp_sync <= 2'h3;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n};
      sck_sync <= {sck_sync[1:0], sck};
      sdi_sync <= {sdi_sync[0], sdi};
      wp_sync <= {wp_sync[0], wp_n};
    end
  end

  // Edges seen after the second stage; data shares the clock's latency
  assign sck_rise = sck_sync[1] & ~sck_sync[2]; // R23
  assign sck_fall = ~sck_sync[1] & sck_sync[2]; // R23
  assign cs_fall = ~cs_sync[1] & cs_sync[2];
  assign cs_rise = cs_sync[1] & ~cs_sync[2];
  assign byte_in = {shift_in, sdi_sync[1]}; // R1
  assign addr_full = {a8, byte_in};
  assign addr_new = addr_full[ADDR_W-1:0]; // R22
  assign status = {spied_pkg::STATUS_ONES, block_protect,
                   write_enable_latch, busy_flag}; // R11
  assign wr_done = busy_flag && (timer == '0);

  // Select needs a high level seen first, then a falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      selected <= 1'b0;
    end else begin
      if (cs_sync[1]) begin
        armed <= 1'b1;
      end
      if (cs_sync[1]) begin
        selected <= 1'b0;
      end else if (cs_fall && armed) begin
        selected <= 1'b1; // R24
      end
    end
  end

  // Command sequencer, one step per rising serial clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OPCODE;
      kind <= K_NONE;
      bit_cnt <= 3'h0;
      shift_in <= 7'h0;
      out_byte <= 8'h0;
      data_byte <= 8'h0;
      data_seen <= 1'b0;
      a8 <= 1'b0;
      lock_sel <= 1'b0;
      addr <= '0;
      id_off <= 4'h0;
    end else if (!selected || cs_sync[1]) begin
      state <= ST_OPCODE; // R26
      kind <= K_NONE;
      bit_cnt <= 3'h0;
      data_seen <= 1'b0;
    end else if (sck_rise) begin
      shift_in <= byte_in[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        unique case (state)
          ST_OPCODE: begin
            state <= ST_WAIT; // R2
            if (byte_in[7:4] == spied_pkg::OP_HIGH_ZERO) begin
              a8 <= byte_in[spied_pkg::OP_A8_BIT]; // R4
              case (byte_in[2:0])
                spied_pkg::OP_SET_WRITE_ENABLE: kind <= K_SET_WE; // R3 R8
                spied_pkg::OP_CLEAR_WRITE_ENABLE: kind <= K_CLR_WE; // R3 R8
                spied_pkg::OP_STATUS_READ: begin
                  out_byte <= status; // R10
                  state <= ST_RD_STATUS; // R3
                end
                spied_pkg::OP_STATUS_WRITE: begin
                  kind <= K_STATUS_WR; // R4
                  state <= ST_DATA;
                end
                spied_pkg::OP_ARRAY_READ: begin
                  if (!busy_flag) begin // R22
                    kind <= K_ARRAY_RD;
                    state <= ST_ADDR;
                  end
                end
                spied_pkg::OP_ARRAY_WRITE: begin
                  kind <= K_ARRAY_WR; // R4
                  state <= ST_ADDR;
                end
                default: state <= ST_WAIT; // R2
              endcase
            end else if (HAS_ID_PAGE) begin // R27
              if (byte_in == spied_pkg::OP_ID_PAGE_READ && !busy_flag) begin
                kind <= K_ID_RD; // R5
                state <= ST_ADDR;
              end else if (byte_in == spied_pkg::OP_ID_PAGE_WRITE) begin
                kind <= K_ID_WR; // R5
                state <= ST_ADDR;
              end
            end
          end
          ST_ADDR: begin
            addr <= addr_new;
            id_off <= byte_in[3:0]; // R6
            lock_sel <= byte_in[spied_pkg::ID_LOCK_SEL_BIT]; // R5
            state <= ST_DATA;
            if (kind == K_ARRAY_RD) begin
              out_byte <= mem[addr_new]; // R20
              state <= ST_RD_ARRAY;
            end else if (kind == K_ID_RD) begin
              if (byte_in[spied_pkg::ID_LOCK_SEL_BIT]) begin
                out_byte <= {7'h0, id_locked};
                state <= ST_RD_LOCK;
              end else begin
                out_byte <= id_mem[byte_in[3:0]];
                state <= ST_RD_ID;
              end
            end
          end
          ST_DATA: begin
            data_byte <= byte_in;
            data_seen <= 1'b1;
          end
          ST_RD_STATUS: out_byte <= status; // R10 R12
          ST_RD_ARRAY: begin
            // Counter width equals the address width, so it wraps to zero
            addr <= addr + ADDR_W'(1); // R20
            out_byte <= mem[addr + ADDR_W'(1)]; // R20
          end
          ST_RD_ID: begin
            id_off <= id_off + 4'h1;
            out_byte <= id_mem[id_off + 4'h1];
          end
          ST_RD_LOCK: out_byte <= {7'h0, id_locked};
          ST_WAIT: out_byte <= out_byte; // R2
        endcase
      end
    end
  end

  // Protect pin must stay high through the whole transfer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_low_seen <= 1'b0;
    end else if (!selected) begin
      wp_low_seen <= 1'b0;
    end else if (!wp_sync[1]) begin
      wp_low_seen <= 1'b1; // R19
    end
  end

  // Write commands count only when deselected on a byte boundary
  assign aligned = cs_rise && selected && state == ST_DATA &&
                   data_seen && bit_cnt == 3'h0; // R16 R17
  assign wr_ok = write_enable_latch && !busy_flag &&
                 !wp_low_seen && wp_sync[1]; // R14 R19
  always_comb begin
    start_wr = 1'b0;
    if (aligned && wr_ok) begin
      case (kind)
        K_STATUS_WR: start_wr = 1'b1;
        K_ARRAY_WR: start_wr = !is_protected(block_protect, addr); // R15
        K_ID_WR: start_wr = block_protect != spied_pkg::BP_ALL &&
                            !id_locked &&
                            (!lock_sel || data_byte[spied_pkg::LOCK_DATA_BIT]);
        default: start_wr = 1'b0;
      endcase
    end
  end

  // Self-timed cycle; busy is high for exactly WRITE_CYCLES clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag <= 1'b0;
      timer <= '0;
      wr_kind <= K_NONE;
      pend_bp <= spied_pkg::BP_RESET;
      wr_addr <= '0;
      wr_id_off <= 4'h0;
      wr_data <= 8'h0;
    end else if (start_wr) begin
      busy_flag <= 1'b1; // R13 R17
      timer <= TW_W'(WRITE_CYCLES - 1);
      wr_kind <= (kind == K_ID_WR && lock_sel) ? K_CLR_WE : kind;
      pend_bp <= data_byte[spied_pkg::STATUS_BP_HI_BIT:
                           spied_pkg::STATUS_BP_LO_BIT]; // R18
      wr_addr <= addr;
      wr_id_off <= id_off;
      wr_data <= data_byte;
    end else if (wr_done) begin
      busy_flag <= 1'b0; // R13
    end else if (busy_flag) begin
      timer <= timer - TW_W'(1);
    end
  end

  // Non-volatile bits change only when a cycle completes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_protect <= spied_pkg::BP_RESET;
      id_locked <= spied_pkg::LOCK_RESET;
    end else if (wr_done) begin
      if (wr_kind == K_STATUS_WR) begin
        block_protect <= pend_bp; // R12 R15 R17
      end
      if (wr_kind == K_CLR_WE) begin
        id_locked <= 1'b1; // Lock write reuses this kind code
      end
    end
  end

  // Array storage has no reset, like the cells it stands for
  always_ff @(posedge sys_clk) begin
    if (wr_done && wr_kind == K_ARRAY_WR) begin
      mem[wr_addr] <= wr_data;
    end
    if (wr_done && wr_kind == K_ID_WR) begin
      id_mem[wr_id_off] <= wr_data;
    end
  end

  // Write enable latch; protect pin low overrides everything, and a
  // set at deselection beats a write cycle ending in the same clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0; // R9
    end else if (!wp_sync[1]) begin
      write_enable_latch <= 1'b0; // R9
    end else if (cs_rise && selected && state == ST_WAIT &&
                 kind == K_SET_WE) begin
      write_enable_latch <= 1'b1; // R7 R8
    end else if (wr_done) begin
      write_enable_latch <= 1'b0; // R9 R18
    end else if (cs_rise && selected && state == ST_WAIT &&
                 kind == K_CLR_WE) begin
      write_enable_latch <= 1'b0; // R9
    end
  end

  // Output drives on falling edges while a read state is active
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (!selected || cs_sync[1]) begin
      sdo <= 1'b0; // R21
      sdo_oe <= 1'b0;
    end else if (sck_fall && (state == ST_RD_STATUS ||
                 state == ST_RD_ARRAY || state == ST_RD_ID ||
                 state == ST_RD_LOCK)) begin
      sdo <= out_byte[3'h7 - bit_cnt]; // R1 R23
      sdo_oe <= 1'b1;
    end
  end

endmodule // spied_core

//--- pkg/spied_pkg.sv
// Shared constants of the serial EEPROM instruction decoder
package spied_pkg;

  // Self-timed write cycle, printed as a time, and its cycle count
  localparam int unsigned SELF_TIMED_WRITE_DURATION_US = 5000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Longest time, so the count rounds down
  localparam int unsigned TW_CYCLES =
    (SELF_TIMED_WRITE_DURATION_US * 1000) / CLK_PERIOD_NS;

  // Opcode fields: upper nibble zero, bit 3 ignored or address bit nine
  localparam logic [3:0] OP_HIGH_ZERO = 4'h0;
  localparam int OP_A8_BIT = 3;
  localparam logic [2:0] OP_SET_WRITE_ENABLE = 3'h6;
  localparam logic [2:0] OP_CLEAR_WRITE_ENABLE = 3'h4;
  localparam logic [2:0] OP_STATUS_READ = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
  localparam logic [2:0] OP_ARRAY_READ = 3'h3;
  localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;
  localparam logic [7:0] OP_ID_PAGE_READ = 8'h83;
  localparam logic [7:0] OP_ID_PAGE_WRITE = 8'h82;

  // Address and data byte bits of the identification page commands
  localparam int ID_LOCK_SEL_BIT = 7;
  localparam int LOCK_DATA_BIT = 1;

  // Status byte layout
  localparam logic [3:0] STATUS_ONES = 4'hf;
  localparam int STATUS_BP_HI_BIT = 3;
  localparam int STATUS_BP_LO_BIT = 2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // Non-volatile bits start from this value after a simulated power-up
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic LOCK_RESET = 1'b0;

endpackage

//--- verif/spied_master.sv
`timescale 1ns/100ps
// Bus master model: clock idles low, bytes go most significant bit first
module spied_master (
  input wire logic sys_clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sck,
  output logic sdi,
  output logic [63:0] rx
);
  // Idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rx = 64'h0;
  end
  // Sends nb bits from the top of tx, then reads nr bytes.
  // Read bits are taken just before each fall, giving the core's
  // resync lag a full high phase to settle. A released output reads
  // as the inverse of the core's idle level, so silence never passes
  // for driven zeros.
  task automatic frame(input logic [23:0] tx, input int nb, input int nr);
    rx = 64'h0;
    @(negedge sys_clk);
    cs_n = 1'b0;
    for (int i = 0; i < nb + 8 * nr; i++) begin
      sdi = (i < nb) ? tx[23 - i] : ~sdi;
      repeat (4) @(negedge sys_clk);
      sck = 1'b1;
      repeat (4) @(negedge sys_clk);
      if (i >= nb) rx = {rx[62:0], sdo_oe ? sdo : ~sdo};
      sck = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule // spied_master

//--- verif/spied_monitor.sv
`timescale 1ns/100ps
// Port-level watcher of the serial decoder; sees only the core's pins
module spied_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic sck_q;
  logic [3:0] fall_age;
  logic [5:0] rise_cnt;
  // Raw clock pin history; bounds below allow for the core's resync lag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end
  // Cycles since the clock pin fell, saturating so it never wraps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_age <= 4'hf;
    end else if (sck_q && !sck) begin
      fall_age <= 4'h0;
    end else if (fall_age != 4'hf) begin
      fall_age <= fall_age + 4'h1;
    end
  end
  // Clock rises within the current frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 6'h00;
    end else if (cs_n) begin
      rise_cnt <= 6'h00;
    end else if (!sck_q && sck && rise_cnt != 6'h3f) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_oe_on_fall: assert property (
    $rose(sdo_oe) |-> fall_age inside {[1:5]})
    else $error("output enable rose away from a clock fall");
  a_out_on_fall: assert property (
    sdo_oe && $changed(sdo) |-> fall_age inside {[1:5]})
    else $error("output bit changed away from a clock fall");
  a_oe_after_byte: assert property (
    $rose(sdo_oe) |-> rise_cnt == 6'h08 || rise_cnt == 6'h10)
    else $error("output started off a byte boundary");
  a_quiet_opcode: assert property (
    !cs_n && rise_cnt < 6'h08 |-> !sdo_oe)
    else $error("output driven during the opcode byte");
  a_oe_holds: assert property (
    (!cs_n)[*4] ##0 sdo_oe |=> sdo_oe)
    else $error("output released while still selected");
  a_oe_drops: assert property (
    $rose(cs_n) |-> ##[1:4] !sdo_oe)
    else $error("output kept after deselect");
  a_idle_quiet: assert property (
    cs_n[*5] |-> !sdo_oe && !sdo)
    else $error("output active while deselected");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> (!sdo_oe)[*8])
    else $error("output active right after reset");
endmodule // spied_monitor
bind spied_core spied_monitor spied_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .sdi(sdi),
  .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe));

//--- verif/testbench.sv
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    n_fail++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); \
  end \
end
module testbench;
  typedef struct {
    logic [23:0] tx;
    int nb;
    int nr;
    logic [15:0] ex;
    int wt;
  } spied_row_t;
  localparam int WC = 600;
  logic sys_clk, rst_n, wp_n, cs_n, sck, sdi, sdo, sdo_oe;
  logic [63:0] rx;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // Frame, bits sent, bytes read, expected read-back, idle cycles after
  spied_row_t rows [0:25] = '{
    '{24'h050000, 8, 1, 16'h00f0, 0},
    '{24'h0e0000, 8, 0, 16'h0000, 0},
    '{24'h0d0000, 8, 1, 16'h00f2, 0},
    '{24'h0c0000, 8, 0, 16'h0000, 0},
    '{24'h050000, 8, 1, 16'h00f0, 0},
    '{24'h060000, 8, 0, 16'h0000, 0},
    '{24'h0affa5, 24, 0, 16'h0000, 0},
    '{24'h050000, 8, 2, 16'hf3f3, 0},
    '{24'h0bff00, 16, 1, 16'h00ff, 650},
    '{24'h050000, 8, 1, 16'h00f0, 0},
    '{24'h060000, 8, 0, 16'h0000, 0},
    '{24'h02003c, 24, 0, 16'h0000, 650},
    '{24'h0bff00, 16, 2, 16'ha53c, 0},
    '{24'h060000, 8, 0, 16'h0000, 0},
    '{24'h010c00, 16, 0, 16'h0000, 0},
    '{24'h050000, 8, 1, 16'h00f3, 650},
    '{24'h050000, 8, 1, 16'h00fc, 0},
    '{24'h060000, 8, 0, 16'h0000, 0},
    '{24'h020077, 24, 0, 16'h0000, 650},
    '{24'h050000, 8, 1, 16'h00fe, 0},
    '{24'h030000, 16, 1, 16'h003c, 0},
    '{24'h470000, 8, 1, 16'h00ff, 0},
    '{24'h838000, 16, 1, 16'h0000, 0},
    '{24'h820011, 24, 0, 16'h0000, 0},
    '{24'h010000, 17, 0, 16'h0000, 0},
    '{24'h050000, 8, 1, 16'h00fe, 0}
  };
  spied_core #(.ADDR_W(9), .HAS_ID_PAGE(1'b1), .WRITE_CYCLES(WC))
    spied_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
    .sck(sck), .sdi(sdi), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe));
  spied_master spied_master_i (.sys_clk(sys_clk), .sdo(sdo),
    .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck), .sdi(sdi), .rx(rx));
  // System clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the length of the whole sequence
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Table traffic, then write protect and a second power-up
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    foreach (rows[k]) begin
      spied_master_i.frame(rows[k].tx, rows[k].nb, rows[k].nr);
      if (rows[k].nr > 0) `CHECK("read back", rows[k].ex, rx[15:0])
      repeat (rows[k].wt) @(negedge sys_clk);
    end
    // Protect pin low drops the latch
    wp_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    spied_master_i.frame(24'h050000, 8, 1);
    `CHECK("status wp low", 16'h00fc, rx[15:0])
    wp_n = 1'b1;
    spied_master_i.frame(24'h060000, 8, 0);
    // A protect glitch inside a status write must cancel it
    fork
      spied_master_i.frame(24'h010000, 16, 0);
      begin
        repeat (40) @(negedge sys_clk);
        wp_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        wp_n = 1'b1;
      end
    join
    spied_master_i.frame(24'h050000, 8, 1);
    `CHECK("status wp glitch", 16'h00fc, rx[15:0])
    // Second power-up in mid-run
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    spied_master_i.frame(24'h050000, 8, 1);
    `CHECK("status reset", {8'h00, spied_pkg::STATUS_ONES,
      spied_pkg::BP_RESET, 2'h0}, rx[15:0])
    // Power-up with chip select already low: no falling edge, no select
    fork
      spied_master_i.frame(24'h050000, 8, 1);
      begin
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
      end
    join
    `CHECK("status unselected", 16'h00ff, rx[15:0])
    spied_master_i.frame(24'h050000, 8, 1);
    `CHECK("status after select", 16'h00f0, rx[15:0])
    end_sim();
  end
endmodule // testbench
